// [spd_pkg.sv]
// Constants and carrier types for the panel drive output stage.
// Assumes a 16-bit display memory address and 16-bit pixel words.
package spd_pkg;

    // ==========================================================
    // Display memory decode windows
    localparam logic [15:0] SPD_BLK0_LO   = 16'h0000;
    localparam logic [15:0] SPD_BLK0_HI   = 16'h07FF;
    localparam logic [15:0] SPD_BLK1_LO   = 16'h0800;
    localparam logic [15:0] SPD_BLK1_HI   = 16'h0FFF;
    localparam logic [15:0] SPD_ADDR_IDLE = 16'hFFFF;
    localparam int          SPD_AREA_BIT  = 15;

    // ==========================================================
    // Shift steps per 16-bit pixel word
    localparam logic [4:0] SPD_STEPS_SGL_SER = 5'h10;
    localparam logic [4:0] SPD_STEPS_SGL_SPL = 5'h08;
    localparam logic [4:0] SPD_STEPS_DUA_SER = 5'h08;
    localparam logic [4:0] SPD_STEPS_DUA_SPL = 5'h04;

    // ==========================================================
    // Reset and stop levels of the panel pins
    localparam logic SPD_ROWSYNC_STOP = 1'b1;
    localparam logic SPD_FRAME_STOP   = 1'b1;
    localparam logic SPD_SELECT_IDLE  = 1'b1;

    // ==========================================================
    // Carriers
    typedef enum logic [1:0] {SPD_IDLE, SPD_ACC, SPD_DONE} spd_mem_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic        write;
        logic        lower;
        logic [7:0]  wdata;
    } spd_mem_req_type;

    typedef struct packed {
        logic uo;
        logic eo;
        logic lo;
        logic uclk;
        logic lclk;
        logic lp;
        logic rs;
        logic fm;
    } spd_panel_type;

endpackage

// [spd_panel_drive.sv]
// Panel drive output stage: memory strobes, pixel FIFO, serializer.
// Assumes panel_osc_clk runs free; scan, format, halt and reset pins are asynchronous strap/level inputs.
// What this block does
// - Single scan: block 0 select low for accesses 0000H to 07FFH.
// - Single scan: block 1 select low for accesses 0800H to 0FFFH.
// - Dual scan: first shared pin carries lower area odd-column pixels.
// - Dual scan: second shared pin carries lower area column shift clock.
// - Upper area odd-column pixels leave on their own pin.
// - Format high: odd/even split, even pin serves both areas.
// - Format low: plain serial stream on the even pin for both areas.
// - Upper area has its own column shift clock.
// - Scan mode input high selects single scan, low dual scan.
// - Line pulse after the last word of each line latches columns, steps rows.
// - Row sync tells row drivers where the scan begins.
// - Frame marker flags the start of each frame.
// - Power control low while halt or reset pin is low.
// - Stop: buses float, r/w high, clocks/line low, sync/frame high.
// - Stop: pixel outputs keep their previous levels.
// - Stop: selects high, or follow graphic pointer in attribute mode.
// - Stop: address all high, or graphic pointer in attribute mode.
// - Dual scan: top address bit low upper area, high lower.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Pixel word FIFO
module spd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } spd_fifo_type;

    spd_fifo_type f_q;
    spd_fifo_type f_d;
    logic         full;
    logic         empty;

    // Extra pointer bit tells full from empty
    assign empty     = (f_q.wp == f_q.rp);
    assign full      = (f_q.wp[AW] != f_q.rp[AW]) && (f_q.wp[AW-1:0] == f_q.rp[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = f_q.mem[f_q.rp[AW-1:0]];

    // Pointer and storage update
    always_comb
    begin
        f_d = f_q;
        if (in_valid && !full)
        begin
            f_d.mem[f_q.wp[AW-1:0]] = in_data;
            f_d.wp = f_q.wp + 1'b1;
        end
        if (out_ready && !empty)
            f_d.rp = f_q.rp + 1'b1;
        if (sys_rst)
        begin
            f_d.wp = '0;
            f_d.rp = '0;
        end
    end

    always_ff @(posedge sys_clk)
        f_q <= f_d;
endmodule

// ==========================================================
// Top level
module spd_panel_drive
    import spd_pkg::*;
#(
    parameter int FIFO_DEPTH     = 16,
    parameter int WORDS_PER_LINE = 40,
    parameter int LINES          = 64
) (
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    input  wire logic            panel_osc_clk,
    input  wire logic            scan_single,
    input  wire logic            pixel_format_sel,
    input  wire logic            panel_halt_n,
    input  wire logic            panel_reset_n,
    input  wire logic            attr_mode,
    input  wire logic [15:0]     graphic_ptr,
    input  wire logic            graphic_ptr_sel_n,
    input  wire logic            host_rd_en,
    output logic                 host_data_oe,
    input  wire logic            pix_valid,
    output logic                 pix_ready,
    input  wire logic [15:0]     pix_word,
    input  wire logic            mem_req_valid,
    output logic                 mem_req_ready,
    input  wire spd_mem_req_type mem_req,
    output logic                 mem_rsp_valid,
    output logic      [7:0]      mem_rsp_data,
    output logic      [15:0]     mem_addr,
    output logic                 mem_ce_n,
    output logic                 mem_rw,
    output logic      [7:0]      mem_data_out,
    output logic                 mem_data_oe,
    input  wire logic [7:0]      mem_data_in,
    output logic                 mem_block0_select_n,
    output logic                 mem_block1_select_n,
    output logic                 upper_odd_pixel_out,
    output logic                 even_pixel_out,
    output logic                 upper_column_shift_clk,
    output logic                 line_latch_pulse,
    output logic                 row_scan_sync,
    output logic                 frame_marker,
    output logic                 panel_power_ctrl
);
    localparam int CW = $clog2(WORDS_PER_LINE);
    localparam int LW = $clog2(LINES);
    localparam logic [CW-1:0] COL_LAST  = CW'(WORDS_PER_LINE - 1);
    localparam logic [LW-1:0] LINE_LAST = LW'(LINES - 1);

    // ==========================================================
    // State of the system clock domain
    typedef struct packed {
        logic              stop1;
        logic              stop2;
        logic              sgl1;
        logic              sgl2;
        logic              ack1;
        logic              ack2;
        logic              xreq;
        logic [15:0]       xword;
        spd_mem_state_type st;
        spd_mem_req_type   req;
        logic [7:0]        rdata;
        logic              rsp_v;
        logic              pwr;
        logic [15:0]       addr;
        logic              ce_n;
        logic              blk0_n;
        logic              blk1_n;
        logic              rw;
        logic [7:0]        dout;
        logic              d_oe;
        logic              h_oe;
    } spd_sys_type;

    // ==========================================================
    // State of the panel oscillator domain
    typedef struct packed {
        logic          rst1;
        logic          rst2;
        logic          stop1;
        logic          stop2;
        logic          sgl1;
        logic          sgl2;
        logic          spl1;
        logic          spl2;
        logic          req1;
        logic          req2;
        logic          req_seen;
        logic          ack;
        logic [15:0]   sh;
        logic          have;
        logic          ph;
        logic          ar;
        logic          lp_pend;
        logic [4:0]    cnt;
        logic [CW-1:0] col;
        logic [LW-1:0] line;
        spd_panel_type pan;
    } spd_link_type;

    spd_sys_type  s_q;
    spd_sys_type  s_d;
    spd_link_type l_q;
    spd_link_type l_d;
    logic         f_valid;
    logic         f_ready;
    logic [15:0]  f_word;
    logic         pin_stop;

    // Halt or reset pin active; combined before synchronising
    assign pin_stop = !(panel_halt_n && panel_reset_n);

    // Crossing slot is free once the link has echoed the toggle
    assign f_ready = (s_q.xreq == s_q.ack2) && !sys_rst;

    spd_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (pix_valid),
        .in_ready  (pix_ready),
        .in_data   (pix_word),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_word)
    );

    // ==========================================================
    // System domain: memory strobes, crossing launch, stop handling
    always_comb
    begin
        logic act;
        logic [15:0] a;
        act = 1'b0;
        a = '0;
        s_d = s_q;
        s_d.stop1 = pin_stop;
        s_d.stop2 = s_q.stop1;
        s_d.sgl1 = scan_single;
        s_d.sgl2 = s_q.sgl1;
        s_d.ack1 = l_q.ack;
        s_d.ack2 = s_q.ack1;
        s_d.rsp_v = 1'b0;
        s_d.pwr = !s_q.stop2;
        // Word held steady in xword until the link echoes the toggle
        if (f_valid && f_ready)
        begin
            s_d.xword = f_word;
            s_d.xreq = !s_q.xreq;
        end
        case (s_q.st)
            SPD_IDLE:
                if (mem_req_valid && !s_q.stop2)
                begin
                    s_d.req = mem_req;
                    s_d.st = SPD_ACC;
                end
            SPD_ACC:
                s_d.st = SPD_DONE;
            SPD_DONE:
            begin
                s_d.rdata = mem_data_in;
                s_d.rsp_v = 1'b1;
                s_d.st = SPD_IDLE;
            end
            default:
                s_d.st = SPD_IDLE;
        endcase
        // Pin levels for the coming cycle
        act = (s_d.st != SPD_IDLE);
        a = s_d.req.addr;
        if (!s_q.sgl2)
            a[SPD_AREA_BIT] = s_d.req.lower;
        s_d.addr = a;
        s_d.ce_n = !act;
        s_d.blk0_n = !(act && s_q.sgl2 && a >= SPD_BLK0_LO && a <= SPD_BLK0_HI);
        s_d.blk1_n = !(act && s_q.sgl2 && a >= SPD_BLK1_LO && a <= SPD_BLK1_HI);
        s_d.rw = !(act && s_d.req.write);
        s_d.d_oe = act && s_d.req.write;
        s_d.dout = s_d.req.wdata;
        s_d.h_oe = host_rd_en;
        if (s_q.stop2)
        begin
            s_d.st = SPD_IDLE;
            s_d.d_oe = 1'b0;
            s_d.h_oe = 1'b0;
            s_d.rw = 1'b1;
            if (attr_mode)
            begin
                s_d.addr = graphic_ptr;
                s_d.ce_n = graphic_ptr_sel_n;
                s_d.blk0_n = graphic_ptr_sel_n || graphic_ptr > SPD_BLK0_HI;
                s_d.blk1_n = graphic_ptr_sel_n || graphic_ptr < SPD_BLK1_LO
                             || graphic_ptr > SPD_BLK1_HI;
            end
            else
            begin
                s_d.addr = SPD_ADDR_IDLE;
                s_d.ce_n = SPD_SELECT_IDLE;
                s_d.blk0_n = SPD_SELECT_IDLE;
                s_d.blk1_n = SPD_SELECT_IDLE;
            end
        end
        if (sys_rst)
        begin
            s_d = '0;
            s_d.addr = SPD_ADDR_IDLE;
            s_d.ce_n = SPD_SELECT_IDLE;
            s_d.blk0_n = SPD_SELECT_IDLE;
            s_d.blk1_n = SPD_SELECT_IDLE;
            s_d.rw = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
        s_q <= s_d;

    // ==========================================================
    // Link domain: serializer, shift clocks, line and frame timing
    always_comb
    begin
        l_d = l_q;
        l_d.rst1 = sys_rst;
        l_d.rst2 = l_q.rst1;
        l_d.stop1 = pin_stop;
        l_d.stop2 = l_q.stop1;
        l_d.sgl1 = scan_single;
        l_d.sgl2 = l_q.sgl1;
        l_d.spl1 = pixel_format_sel;
        l_d.spl2 = l_q.spl1;
        l_d.req1 = s_q.xreq;
        l_d.req2 = l_q.req1;
        l_d.pan.uclk = 1'b0;
        l_d.pan.lclk = 1'b0;
        l_d.pan.lp = 1'b0;
        if (l_q.rst2 || l_q.stop2)
        begin
            // Counters cleared so the scan restarts at the first line
            l_d.have = 1'b0;
            l_d.ph = 1'b0;
            l_d.ar = 1'b0;
            l_d.lp_pend = 1'b0;
            l_d.col = '0;
            l_d.line = '0;
            l_d.pan.rs = SPD_ROWSYNC_STOP;
            l_d.pan.fm = SPD_FRAME_STOP;
            // Pixel pins untouched during a stop
            if (l_q.rst2)
            begin
                l_d.req_seen = 1'b0;
                l_d.ack = 1'b0;
                l_d.pan.uo = 1'b0;
                l_d.pan.eo = 1'b0;
                l_d.pan.lo = 1'b0;
            end
        end
        else if (!l_q.have)
        begin
            if (l_q.lp_pend)
            begin
                // Latch only after the last shift edge has gone low
                l_d.pan.lp = 1'b1;
                l_d.lp_pend = 1'b0;
            end
            else if (l_q.req2 != l_q.req_seen)
            begin
                // xword is stable: sys side waits for the echo
                l_d.sh = s_q.xword;
                l_d.have = 1'b1;
                l_d.req_seen = l_q.req2;
                l_d.ack = !l_q.ack;
                l_d.ph = 1'b0;
                l_d.ar = 1'b0;
                if (l_q.sgl2)
                    l_d.cnt = l_q.spl2 ? SPD_STEPS_SGL_SPL : SPD_STEPS_SGL_SER;
                else
                    l_d.cnt = l_q.spl2 ? SPD_STEPS_DUA_SPL : SPD_STEPS_DUA_SER;
            end
        end
        else if (!l_q.ph)
        begin
            // Data set up while the shift clock is low
            if (!l_q.ar)
            begin
                if (l_q.spl2)
                begin
                    l_d.pan.uo = l_q.sh[15];
                    l_d.pan.eo = l_q.sh[14];
                end
                else
                    l_d.pan.eo = l_q.sh[15];
            end
            else
            begin
                if (l_q.spl2)
                begin
                    l_d.pan.lo = l_q.sh[7];
                    l_d.pan.eo = l_q.sh[6];
                end
                else
                    l_d.pan.eo = l_q.sh[7];
            end
            l_d.ph = 1'b1;
        end
        else
        begin
            if (!l_q.ar)
                l_d.pan.uclk = 1'b1;
            else
                l_d.pan.lclk = 1'b1;
            l_d.ph = 1'b0;
            if (!l_q.sgl2 && !l_q.ar)
                l_d.ar = 1'b1;
            else
            begin
                l_d.ar = 1'b0;
                if (l_q.sgl2)
                    l_d.sh = l_q.spl2 ? {l_q.sh[13:0], 2'b00} : {l_q.sh[14:0], 1'b0};
                else if (l_q.spl2)
                    l_d.sh = {l_q.sh[13:8], 2'b00, l_q.sh[5:0], 2'b00};
                else
                    l_d.sh = {l_q.sh[14:8], 1'b0, l_q.sh[6:0], 1'b0};
                l_d.cnt = l_q.cnt - 5'h01;
                if (l_q.cnt == 5'h01)
                begin
                    l_d.have = 1'b0;
                    l_d.col = l_q.col + 1'b1;
                    if (l_q.col == COL_LAST)
                    begin
                        l_d.col = '0;
                        l_d.lp_pend = 1'b1;
                        l_d.line = (l_q.line == LINE_LAST) ? '0 : l_q.line + 1'b1;
                        l_d.pan.rs = (l_q.line == LINE_LAST);
                        if (l_q.line == LINE_LAST)
                            l_d.pan.fm = !l_q.pan.fm;
                    end
                end
            end
        end
        // Stop levels win over everything above
        if (l_q.stop2)
        begin
            l_d.pan.uclk = 1'b0;
            l_d.pan.lclk = 1'b0;
            l_d.pan.lp = 1'b0;
            l_d.pan.uo = l_q.pan.uo;
            l_d.pan.eo = l_q.pan.eo;
            l_d.pan.lo = l_q.pan.lo;
        end
    end

    always_ff @(posedge panel_osc_clk)
        l_q <= l_d;

    // ==========================================================
    // Pin assignment; shared pins chosen by the scan strap
    assign mem_block0_select_n    = s_q.sgl2 ? s_q.blk0_n : l_q.pan.lo;
    assign mem_block1_select_n    = s_q.sgl2 ? s_q.blk1_n : l_q.pan.lclk;
    assign upper_odd_pixel_out    = l_q.pan.uo;
    assign even_pixel_out         = l_q.pan.eo;
    assign upper_column_shift_clk = l_q.pan.uclk;
    assign line_latch_pulse       = l_q.pan.lp;
    assign row_scan_sync          = l_q.pan.rs;
    assign frame_marker           = l_q.pan.fm;
    assign panel_power_ctrl       = s_q.pwr;
    assign mem_addr               = s_q.addr;
    assign mem_ce_n               = s_q.ce_n;
    assign mem_rw                 = s_q.rw;
    assign mem_data_out           = s_q.dout;
    assign mem_data_oe            = s_q.d_oe;
    assign host_data_oe           = s_q.h_oe;
    assign mem_rsp_valid          = s_q.rsp_v;
    assign mem_rsp_data           = s_q.rdata;
    assign mem_req_ready          = (s_q.st == SPD_IDLE) && !s_q.stop2;
endmodule

`default_nettype wire

// [spd_chk.sv]
// Port checker for the panel drive stage, bound to its top module.
// Assumes no stop pin falls while a memory access is in flight.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port-level properties
module spd_chk
    import spd_pkg::*;
(
    input wire logic            sys_clk,
    input wire logic            sys_rst,
    input wire logic            panel_osc_clk,
    input wire logic            scan_single,
    input wire logic            panel_halt_n,
    input wire logic            panel_reset_n,
    input wire logic            attr_mode,
    input wire logic [15:0]     graphic_ptr,
    input wire logic            mem_req_valid,
    input wire logic            mem_req_ready,
    input wire spd_mem_req_type mem_req,
    input wire logic            mem_rsp_valid,
    input wire logic [15:0]     mem_addr,
    input wire logic            mem_ce_n,
    input wire logic            mem_rw,
    input wire logic            mem_block0_select_n,
    input wire logic            mem_block1_select_n,
    input wire logic            upper_odd_pixel_out,
    input wire logic            even_pixel_out,
    input wire logic            upper_column_shift_clk,
    input wire logic            line_latch_pulse,
    input wire logic            row_scan_sync,
    input wire logic            frame_marker,
    input wire logic            panel_power_ctrl
);
    // Either stop pin low means stop; requests only count while running
    wire stop = !(panel_halt_n && panel_reset_n);
    wire go   = mem_req_valid && mem_req_ready && !stop;
    wire acc  = !mem_ce_n && !stop;
    // Access walk: two strobe cycles, then the answer with pins idle
    sequence strobe_s;
        !mem_ce_n [*2];
    endsequence
    sequence answer_s;
        mem_rsp_valid && mem_ce_n;
    endsequence
    mem_walk_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        go |=> strobe_s ##1 answer_s) else $error("memory access walk wrong");
    blk0_dec_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc && scan_single && mem_addr <= 16'h07FF |-> !mem_block0_select_n && mem_block1_select_n)
        else $error("block 0 select wrong");
    blk1_dec_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc && scan_single && mem_addr inside {[16'h0800:16'h0FFF]} |-> mem_block0_select_n && !mem_block1_select_n)
        else $error("block 1 select wrong");
    area_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        go && !scan_single |=> mem_addr[15] == $past(mem_req.lower)) else $error("area address bit wrong");
    power_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stop [*5] |-> !panel_power_ctrl) else $error("panel power not off");
    stop_pins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (stop && !attr_mode) [*5] |-> mem_addr == 16'hFFFF && mem_rw && mem_ce_n) else $error("stop levels wrong");
    attr_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (stop && attr_mode) [*5] |-> mem_addr == graphic_ptr) else $error("pointer not shown in stop");
    lp_one_a: assert property (@(posedge panel_osc_clk) disable iff (sys_rst)
        $rose(line_latch_pulse) |=> !line_latch_pulse) else $error("line pulse too long");
    link_stop_a: assert property (@(posedge panel_osc_clk) disable iff (sys_rst)
        stop [*6] |-> !upper_column_shift_clk && !line_latch_pulse && row_scan_sync && frame_marker)
        else $error("panel stop levels wrong");
    pix_hold_a: assert property (@(posedge panel_osc_clk) disable iff (sys_rst)
        stop [*6] |-> $stable(upper_odd_pixel_out) && $stable(even_pixel_out)) else $error("pixel pins moved");
endmodule
bind spd_panel_drive spd_chk spd_chk_inst (.*);
`default_nettype wire

// [spd_col_model.sv]
// Behavioural column and row driver pair watching the panel pins.
// Assumes a shift clock never rises together with the line pulse.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Panel driver model
module spd_col_model (
    input  wire logic   up_clk,
    input  wire logic   lo_clk,
    input  wire logic   ser_in,
    input  wire logic   latch,
    input  wire logic   frame,
    output logic [31:0] line_bits,
    output int          up_cnt = 0,
    output int          lo_cnt = 0,
    output int          lines = 0,
    output int          frames = 0,
    output int          lines_frame = 0
);
    logic [31:0] sh_q;
    int          up_tot = 0;
    int          lo_tot = 0;
    int          up_mk = 0;
    int          lo_mk = 0;
    int          ln_mk = 0;
    // Column data enters on the rising shift clock, first bit oldest
    always @(posedge up_clk)
    begin
        sh_q   <= {sh_q[30:0], ser_in};
        up_tot <= up_tot + 1;
    end
    // Lower area clock is only counted
    always @(posedge lo_clk) lo_tot <= lo_tot + 1;
    // Latch takes the line and steps the rows; totals avoid two drivers
    always @(posedge latch)
    begin
        line_bits <= sh_q;
        up_cnt    <= up_tot - up_mk;
        up_mk     <= up_tot;
        lo_cnt    <= lo_tot - lo_mk;
        lo_mk     <= lo_tot;
        lines     <= lines + 1;
    end
    // Either edge of the frame marker opens a new frame
    always @(frame)
    begin
        lines_frame <= lines - ln_mk;
        ln_mk       <= lines;
        frames      <= frames + 1;
    end
endmodule
`default_nettype wire

// [stn_panel_drive_outputs_test.sv]
// Self-checking bench for the panel drive stage with a panel model.
// Assumes the package, design, checker and model are compiled first.
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module stn_panel_drive_outputs_test
    import spd_pkg::*;
;
    localparam int WPL = 2;
    localparam int NL  = 4;
    logic sys_clk = 1'h0, sys_rst = 1'h1, panel_osc_clk = 1'h0, scan_single = 1'h1, pixel_format_sel = 1'h0;
    logic panel_halt_n = 1'h1, panel_reset_n = 1'h1, attr_mode = 1'h0, graphic_ptr_sel_n = 1'h1, host_rd_en = 1'h0;
    logic pix_valid = 1'h0, mem_req_valid = 1'h0, host_data_oe, pix_ready, mem_req_ready, mem_rsp_valid, mem_ce_n;
    logic mem_rw, mem_data_oe, mem_block0_select_n, mem_block1_select_n, upper_odd_pixel_out, even_pixel_out;
    logic upper_column_shift_clk, line_latch_pulse, row_scan_sync, frame_marker, panel_power_ctrl;
    logic [15:0] graphic_ptr = 16'h0000, pix_word = 16'h0000, mem_addr, first_w [2];
    logic [15:0] win [6] = '{16'h0000, 16'h07FF, 16'h0800, 16'h0FFF, 16'h1000, 16'hF7FF};
    logic [7:0] mem_rsp_data, mem_data_out, mem_data_in;
    logic [31:0] line_bits;
    spd_mem_req_type mem_req = '0;
    int up_cnt, lo_cnt, lines, frames, lines_frame, n_errors = 0, n_checks = 0, nw = 0, l0, f0, k, m;
    // Clocks with unrelated phase; host strobe wanders at random
    always #10 sys_clk = ~sys_clk;
    always #24 panel_osc_clk = ~panel_osc_clk;
    always @(posedge sys_clk) host_rd_en <= 1'($urandom);
    // Memory answers while selected for read, else a moving pattern
    assign mem_data_in = (!mem_ce_n && mem_rw) ? mem_addr[7:0] ^ 8'h5A : {8{sys_clk}} ^ 8'h3C;
    spd_panel_drive #(.WORDS_PER_LINE(WPL), .LINES(NL)) spd_panel_drive_inst (.*);
    spd_col_model spd_col_model_inst (.up_clk(upper_column_shift_clk), .lo_clk(mem_block1_select_n),
        .ser_in(even_pixel_out), .latch(line_latch_pulse), .frame(frame_marker), .line_bits(line_bits),
        .up_cnt(up_cnt), .lo_cnt(lo_cnt), .lines(lines), .frames(frames), .lines_frame(lines_frame));
    // Shift clocks per line: bits per area and word, over data pins
    function automatic int exp_clks(input logic s, input logic f);
        return (s ? 16 : 8) / (f ? 2 : 1) * WPL;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One access held until taken, then its single-cycle answer
    task automatic mem_op(input logic [15:0] a, input logic w, input logic lo);
        mem_req = '{addr: a, write: w, lower: lo, wdata: a[7:0]};
        mem_req_valid = 1'h1;
        @(posedge sys_clk);
        for (k = 0; k < 20 && !mem_req_ready; k++) @(posedge sys_clk);
        #1 mem_req_valid = 1'h0;
        chk({mem_ce_n, mem_data_oe, mem_rw, mem_data_out}, {1'b0, w, !w, a[7:0]});
        for (k = 0; k < 8 && !mem_rsp_valid; k++) tick(1);
        chk(mem_rsp_valid, 1);
        if (!w) chk(mem_rsp_data, a[7:0] ^ 8'h5A);
    endtask
    // Pixel words, each held until the edge that takes it
    task automatic push(input int n, input int lim);
        logic t;
        pix_word = 16'($urandom);
        pix_valid = 1'h1;
        for (k = 0; k < lim && n > 0; k++)
        begin
            @(posedge sys_clk);
            t = pix_ready;
            #1;
            if (t)
            begin
                if (nw < 2) first_w[nw] = pix_word;
                nw++;
                n--;
                pix_word = 16'($urandom);
            end
        end
        pix_valid = 1'h0;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence; reset longer than asked so the link domain sees it
    initial
    begin
        void'($urandom(36));
        tick(12);
        sys_rst = 1'h0;
        tick(3);
        foreach (win[i]) mem_op(win[i], i[0], 1'h0);
        graphic_ptr = 16'($urandom);
        graphic_ptr_sel_n = 1'($urandom);
        attr_mode = 1'h1;
        panel_halt_n = 1'h0;
        tick(8);
        chk({mem_addr, mem_ce_n}, {graphic_ptr, graphic_ptr_sel_n});
        chk(panel_power_ctrl, 0);
        graphic_ptr_sel_n = 1'h1;
        attr_mode = 1'h0;
        tick(8);
        chk({mem_addr, mem_block0_select_n, mem_block1_select_n, mem_rw, host_data_oe, mem_data_oe},
            21'h1F_FFFC);
        panel_halt_n = 1'h1;
        tick(6);
        chk(panel_power_ctrl, 1);
        push(40, 40);
        chk(pix_ready, 0);
        for (k = 0; k < 3000 && lines < 1; k++) tick(1);
        chk(line_bits, {first_w[0], first_w[1]});
        for (m = 0; m < 4; m++)
        begin
            panel_reset_n = 1'h0;
            scan_single = !m[1];
            pixel_format_sel = m[0];
            tick(10);
            panel_reset_n = 1'h1;
            tick(4);
            if (!scan_single) mem_op(16'($urandom), 1'h0, m[0]);
            l0 = lines;
            f0 = frames;
            push(40, 8000);
            for (k = 0; k < 20000 && (lines < l0 + 3 || frames < f0 + 3); k++) tick(1);
            chk(up_cnt, exp_clks(scan_single, m[0]));
            chk(lo_cnt, scan_single ? 0 : exp_clks(1'h0, m[0]));
            chk(lines_frame, NL);
        end
        close_out();
    end
    // Watchdog, well past the expected run length
    initial
    begin
        #(1_000_000);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
